//--- src/iox_pkg.sv
// Package for the I/O expander slave: widths, bus codes and states.
// Assumes one system clock domain; bus pins are sampled, not clocked on.
package iox_pkg;
    localparam int PORT_W = 8;
    localparam int NUM_PORTS = 2;
    localparam int IO_W = 16;
    localparam int ADDR_W = 7;
    localparam int SYNC_STAGES = 2;
    // Fixed upper address bits; lower three come from the select pins
    localparam logic [3:0] ADDR_HI = 4'h4;
    // Command byte layout
    localparam logic [7:0] CMD_IN0 = 8'h00;
    localparam logic [7:0] CMD_IN1 = 8'h01;
    localparam logic [7:0] CMD_OUT0 = 8'h02;
    localparam logic [7:0] CMD_OUT1 = 8'h03;
    localparam logic [7:0] CMD_POL0 = 8'h04;
    localparam logic [7:0] CMD_POL1 = 8'h05;
    localparam logic [7:0] CMD_CFG0 = 8'h06;
    localparam logic [7:0] CMD_CFG1 = 8'h07;
    localparam logic [2:0] CMD_IDX_MASK = 3'h7;
    // Reset values: all pins inputs, outputs high, no inversion
    localparam logic [7:0] CFG_RST = 8'hff;
    localparam logic [7:0] OUT_RST = 8'hff;
    localparam logic [7:0] POL_RST = 8'h00;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_ZERO = 4'h0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_CMD = 3'h2,
        ST_WDATA = 3'h3,
        ST_RDATA = 3'h4,
        ST_IGNORE = 3'h5
    } iox_state_t;
endpackage

//--- src/iox_edge_if.sv
// Interface carrying synchronised bus pin levels and their edge events.
// Assumes both ends run on clk_sys.
interface iox_edge_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    modport prod (output scl, sda, scl_rise, scl_fall, start_det, stop_det);
    modport cons (input scl, sda, scl_rise, scl_fall, start_det, stop_det);
endinterface

//--- src/iox_bus_sense.sv
// Synchronises SCL and SDA and detects clock edges, START and STOP.
// Assumes pins are asynchronous to clk_sys.
module iox_bus_sense
    import iox_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Raw bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    // Conditioned events
    iox_edge_if.prod ev
);
    logic [SYNC_STAGES-1:0] scl_sync_q, scl_sync_d;
    logic [SYNC_STAGES-1:0] sda_sync_q, sda_sync_d;
    logic scl_prev_q, scl_prev_d;
    logic sda_prev_q, sda_prev_d;

    // Shift pins in and keep the previous settled levels
    always_comb begin
        scl_sync_d = {scl_sync_q[0], scl_in};
        sda_sync_d = {sda_sync_q[0], sda_in};
        scl_prev_d = scl_sync_q[1];
        sda_prev_d = sda_sync_q[1];
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            scl_sync_q <= '1;
            sda_sync_q <= '1;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= scl_sync_d;
            sda_sync_q <= sda_sync_d;
            scl_prev_q <= scl_prev_d;
            sda_prev_q <= sda_prev_d;
        end
    end

    // SDA moving while SCL stays high is a control condition
    assign ev.scl = scl_prev_q;
    assign ev.sda = sda_prev_q;
    assign ev.scl_rise = scl_sync_q[1] & ~scl_prev_q;
    assign ev.scl_fall = ~scl_sync_q[1] & scl_prev_q;
    assign ev.start_det = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
    assign ev.stop_det = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];
endmodule

//--- src/iox_top.sv
// I2C slave 16-bit I/O expander with change-detect interrupt.
// Assumes an external master on SCL/SDA and open-drain pads outside.
module iox_top
    import iox_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // I2C bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Address select straps
    input wire logic slave_addr_sel0,
    input wire logic slave_addr_sel1,
    input wire logic slave_addr_sel2,
    // General purpose pins
    input wire logic [IO_W-1:0] io_in,
    output logic [IO_W-1:0] io_out,
    output logic [IO_W-1:0] io_oe,
    // Interrupt, open drain
    output logic int_out,
    output logic int_oe
);
    iox_edge_if ev ();

    iox_bus_sense u_sense (
        .clk_sys(clk_sys),
        .reset(reset),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ev(ev)
    );

    logic [IO_W-1:0] io_s1_q, io_s2_q;
    logic [2:0] ad_s1_q, ad_s2_q;
    iox_state_t st_q, st_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    logic [7:0] cmd_q, cmd_d;
    logic drive_q, drive_d;
    logic [IO_W-1:0] in_q, in_d;
    logic [IO_W-1:0] out_q, out_d;
    logic [IO_W-1:0] pol_q, pol_d;
    logic [IO_W-1:0] cfg_q, cfg_d;
    logic [NUM_PORTS-1:0] pend_q, pend_d;
    logic [7:0] rd_byte;
    logic [ADDR_W-1:0] my_addr;
    logic [NUM_PORTS-1:0] mism;
    logic [NUM_PORTS-1:0] rd_clr;
    logic ack_fall;
    logic rd_ack_fall;
    logic load_fall;
    logic [2:0] next_idx;
    logic reload_q, reload_d;

    // Two-flop synchronisers for pins and straps
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            io_s1_q <= '1;
            io_s2_q <= '1;
            ad_s1_q <= '0;
            ad_s2_q <= '0;
        end else begin
            io_s1_q <= io_in;
            io_s2_q <= io_s1_q;
            ad_s1_q <= {slave_addr_sel2, slave_addr_sel1, slave_addr_sel0};
            ad_s2_q <= ad_s1_q;
        end
    end

    assign my_addr = {ADDR_HI, ad_s2_q};
    assign ack_fall = ev.scl_fall && (bit_q == BIT_ACK);
    assign rd_ack_fall = ack_fall && (st_q == ST_RDATA);
    // Acknowledge falls that start a byte out: after the read address, or after a master acknowledge
    assign load_fall = (ack_fall && st_q == ST_ADDR && sh_q[0]) || (rd_ack_fall && !ev.sda);
    // Register index of that byte; the low command bit selects within the pair
    assign next_idx = (st_q == ST_RDATA) ? (cmd_q[2:0] ^ CMD_IN1[2:0]) : cmd_q[2:0];

    // Read data mux, polarity applied per bit
    always_comb begin
        case (cmd_q[2:0] & CMD_IDX_MASK)
            CMD_IN0[2:0]: rd_byte = in_q[7:0] ^ pol_q[7:0];
            CMD_IN1[2:0]: rd_byte = in_q[15:8] ^ pol_q[15:8];
            CMD_OUT0[2:0]: rd_byte = out_q[7:0];
            CMD_OUT1[2:0]: rd_byte = out_q[15:8];
            CMD_POL0[2:0]: rd_byte = pol_q[7:0];
            CMD_POL1[2:0]: rd_byte = pol_q[15:8];
            CMD_CFG0[2:0]: rd_byte = cfg_q[7:0];
            default: rd_byte = cfg_q[15:8];
        endcase
    end

    // Per-port mismatch between live inputs and captured register
    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p++) begin : g_port
            // Only input-configured pins count; outputs are masked out
            assign mism[p] = |((io_s2_q[p*PORT_W +: PORT_W] ^ in_q[p*PORT_W +: PORT_W])
                               & cfg_q[p*PORT_W +: PORT_W]);
            // Capture strobe: this port is the next byte to go out on a read
            assign rd_clr[p] = load_fall && (next_idx == 3'(p));
        end
    endgenerate

    // Bus state machine: framing, acknowledge and register access
    always_comb begin
        st_d = st_q;
        bit_d = bit_q;
        sh_d = sh_q;
        cmd_d = cmd_q;
        drive_d = drive_q;
        out_d = out_q;
        pol_d = pol_q;
        cfg_d = cfg_q;
        in_d = in_q;
        reload_d = load_fall;
        // Only the port about to be sent is recaptured, so the other port keeps its pending change
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (rd_clr[i]) begin
                in_d[i*PORT_W +: PORT_W] = io_s2_q[i*PORT_W +: PORT_W];
            end
        end
        if (ev.stop_det) begin
            st_d = ST_IDLE;
            drive_d = 1'b0;
        end else if (ev.start_det) begin
            st_d = ST_ADDR;
            // The clock fall that ends the START carries no bit; it wraps this count to zero
            bit_d = ~BIT_ZERO;
            drive_d = 1'b0;
        end else if (st_q != ST_IDLE && st_q != ST_IGNORE) begin
            if (ev.scl_rise && bit_q <= BIT_LAST) begin
                sh_d = {sh_q[6:0], ev.sda};
            end
            if (ev.scl_rise && bit_q == BIT_ACK && st_q == ST_RDATA && ev.sda) begin
                st_d = ST_IGNORE;
            end
            if (ev.scl_fall) begin
                if (bit_q == BIT_LAST) begin
                    bit_d = BIT_ACK;
                    drive_d = 1'b0;
                    case (st_q)
                        ST_ADDR: begin
                            if (sh_q[7:1] == my_addr) begin
                                drive_d = 1'b1;
                            end else begin
                                st_d = ST_IGNORE;
                            end
                        end
                        ST_CMD: begin
                            cmd_d = sh_q;
                            drive_d = 1'b1;
                        end
                        ST_WDATA: begin
                            drive_d = 1'b1;
                            case (cmd_q[2:0])
                                CMD_OUT0[2:0]: out_d[7:0] = sh_q;
                                CMD_OUT1[2:0]: out_d[15:8] = sh_q;
                                CMD_POL0[2:0]: pol_d[7:0] = sh_q;
                                CMD_POL1[2:0]: pol_d[15:8] = sh_q;
                                CMD_CFG0[2:0]: cfg_d[7:0] = sh_q;
                                CMD_CFG1[2:0]: cfg_d[15:8] = sh_q;
                                default: ;
                            endcase
                        end
                        default: ;
                    endcase
                end else if (bit_q == BIT_ACK) begin
                    bit_d = BIT_ZERO;
                    drive_d = 1'b0;
                    case (st_q)
                        ST_ADDR: begin
                            if (sh_q[0]) begin
                                st_d = ST_RDATA; // First byte loads on the following cycle
                            end else begin
                                st_d = ST_CMD;
                            end
                        end
                        ST_CMD: st_d = ST_WDATA;
                        ST_WDATA: cmd_d = cmd_q ^ 8'h01;
                        ST_RDATA: begin
                            cmd_d = cmd_q ^ 8'h01;
                        end
                        default: ;
                    endcase
                end else begin
                    bit_d = bit_q + 4'h1;
                    if (st_q == ST_RDATA) begin
                        drive_d = ~sh_q[7];
                    end
                end
            end
        end
        // Read byte loads one cycle after the acknowledge fall, once pair index and capture have settled
        if (reload_q && st_q == ST_RDATA) begin
            sh_d = rd_byte;
            drive_d = ~rd_byte[7];
        end
    end

    // Register the state
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            reload_q <= 1'b0;
            st_q <= ST_IDLE;
            bit_q <= BIT_ZERO;
            sh_q <= '0;
            cmd_q <= CMD_IN0;
            drive_q <= 1'b0;
            in_q <= '1;
            out_q <= {OUT_RST, OUT_RST};
            pol_q <= {POL_RST, POL_RST};
            cfg_q <= {CFG_RST, CFG_RST};
        end else begin
            reload_q <= reload_d;
            st_q <= st_d;
            bit_q <= bit_d;
            cmd_q <= cmd_d;
            in_q <= in_d;
            out_q <= out_d;
            pol_q <= pol_d;
            cfg_q <= cfg_d;
            sh_q <= sh_d;
            drive_q <= drive_d;
        end
    end

    // Pending flag per port: follows mismatch, dropped by a read of that port
    always_comb begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            pend_d[i] = mism[i] & (pend_q[i] | ~rd_clr[i]);
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pend_q <= '0;
        end else begin
            pend_q <= pend_d;
        end
    end

    // Pin drivers
    assign sda_out = 1'b0;
    assign sda_oe = drive_q;
    assign io_out = out_q;
    assign io_oe = ~cfg_q;
    assign int_out = 1'b0;
    assign int_oe = |pend_q;
endmodule

//--- sim/iox_top_sva.sv
// Checker for the expander's bus acknowledge and interrupt pins.
// Assumes scl_in and sda_in carry the resolved wire levels.
module iox_top_sva
    import iox_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Bus wires and pins
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_oe,
    input wire logic slave_addr_sel0,
    input wire logic slave_addr_sel1,
    input wire logic slave_addr_sel2,
    input wire logic [IO_W-1:0] io_oe,
    input wire logic int_out,
    input wire logic int_oe
);
    // Bit framing tracker: bit count, shifted byte, addressed direction
    logic scl_q, scl_d, sda_q, sda_d, first_q, first_d, wr_q, wr_d, rd_q, rd_d;
    logic rise, ctl, ack, hit;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d;
    always_comb begin
        rise = scl_in & ~scl_q;
        ctl = scl_in & scl_q & (sda_in ^ sda_q);
        ack = rise & (bit_q == BIT_ACK);
        hit = first_q & (sh_q[7:1] == {ADDR_HI, slave_addr_sel2, slave_addr_sel1, slave_addr_sel0});
        {scl_d, sda_d} = {scl_in, sda_in};
        {first_d, wr_d, rd_d, bit_d, sh_d} = {first_q, wr_q, rd_q, bit_q, sh_q};
        if (ctl) begin
            {first_d, wr_d, rd_d, bit_d} = {3'h4, BIT_ZERO};
        end else if (ack) begin
            {first_d, bit_d} = {1'b0, BIT_ZERO};
            if (hit) begin
                {wr_d, rd_d} = {~sh_q[0], sh_q[0]};
            end
        end else if (rise) begin
            bit_d = bit_q + 4'h1;
            sh_d = {sh_q[6:0], sda_in};
        end
    end
    // Registers of the tracker; idle bus reads as both lines high
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            {scl_q, sda_q, first_q, wr_q, rd_q, bit_q, sh_q} <= {2'h3, 3'h0, 4'h0, 8'h00};
        end else begin
            {scl_q, sda_q, first_q, wr_q, rd_q, bit_q, sh_q} <= {scl_d, sda_d, first_d, wr_d, rd_d, bit_d, sh_d};
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_addr_ack: assert property (ack && hit |-> sda_oe)
        else $error("own address not acknowledged");
    a_data_ack: assert property (ack && wr_q |-> sda_oe)
        else $error("written byte not acknowledged");
    a_miss_quiet: assert property (ack && first_q && !hit |-> !sda_oe)
        else $error("foreign address acknowledged");
    a_read_release: assert property (ack && rd_q |-> !sda_oe)
        else $error("data line held in master acknowledge slot");
    a_nack_release: assert property (ack && rd_q && sda_in |-> ##30 !sda_oe)
        else $error("data line driven after read ended");
    a_stable_high: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data line changed while clock high");
    a_start_quiet: assert property (ctl && !sda_in |-> !sda_oe [*8])
        else $error("data line driven at start");
    a_stop_quiet: assert property (ctl && sda_in |-> ##1 !sda_oe [*8])
        else $error("data line driven after stop");
    a_int_source: assert property ($rose(int_oe) |-> io_oe != {IO_W{1'b1}} && int_out == 1'b0)
        else $error("interrupt raised with no input pin");
    c_read_nack: cover property (ack && rd_q && sda_in);
    c_write_ack: cover property (ack && wr_q);
    c_int_rise: cover property ($rose(int_oe));
endmodule
bind iox_top iox_top_sva i_sva (.clk_sys(clk_sys), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
    .sda_oe(sda_oe), .slave_addr_sel0(slave_addr_sel0), .slave_addr_sel1(slave_addr_sel1),
    .slave_addr_sel2(slave_addr_sel2), .io_oe(io_oe), .int_out(int_out), .int_oe(int_oe));

//--- sim/iox_i2c_master.sv
// Bus master model driving SCL and pulling SDA low.
// Assumes SDA is resolved outside with a pull-up.
module iox_i2c_master (
    // Clock and wire level
    input wire logic clk_sys,
    input wire logic sda,
    // Driven lines
    output logic scl,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    int extra = 0;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Quarter bus period; extra stretches it for a slow master
    task automatic q;
        repeat (10 + extra) @(negedge clk_sys);
    endtask
    // Start or repeated start from a released line
    task automatic start_c;
        sda_low = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic stop_c;
        sda_low = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b0;
        q();
    endtask
    // Data set while clock low, held through the high phase
    task automatic bit_x(input logic b, output logic r);
        sda_low = !b;
        q();
        scl = 1'b1;
        q();
        r = sda;
        q();
        scl = 1'b0;
        q();
    endtask
    // Byte then ninth pulse; ab low acknowledges, high releases
    task automatic xfer(input logic [7:0] tx, input logic ab, output logic [7:0] rx, output logic ak);
        for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
        bit_x(ab, ak);
    endtask
endmodule

//--- sim/test_io_expander_irq_and_bus_slave.sv
// Testbench for the expander: bus reads, writes and interrupt.
// Assumes the bus master model and the bound checker.
module test_io_expander_irq_and_bus_slave
    import iox_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [2:0] sel = 3'h5;
    logic [IO_W-1:0] io_in = 16'h1234;
    logic sda_oe, sda_out, int_oe, scl, sda_low;
    logic [IO_W-1:0] io_out, io_oe;
    // Wired data line with pull-up: released reads high
    wire logic sda = sda_low ? 1'b0 : (sda_oe ? sda_out : 1'b1);
    int failures = 0;
    int comparisons = 0;
    int cyc = 0;
    always #2 clk_sys = ~clk_sys;
    iox_top i_dut (.clk_sys(clk_sys), .reset(reset), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .slave_addr_sel0(sel[0]), .slave_addr_sel1(sel[1]), .slave_addr_sel2(sel[2]), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .int_out(), .int_oe(int_oe));
    iox_i2c_master i_mst (.clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(sda_low));
    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One byte from the master, device must acknowledge
    task automatic put(logic [7:0] b);
        logic [7:0] rx;
        logic ak;
        i_mst.xfer(b, 1'b1, rx, ak);
        chk("ack", 16'(ak), 16'h0000);
    endtask
    // Address, command, then n bytes written or read and compared
    task automatic seq(logic [7:0] c, logic [23:0] d, int n, logic rd);
        logic [7:0] rx;
        logic ak;
        i_mst.start_c();
        put({ADDR_HI, sel, 1'b0});
        put(c);
        if (rd) begin
            i_mst.start_c();
            put({ADDR_HI, sel, 1'b1});
        end
        for (int i = 0; i < n; i++) begin
            if (rd) i_mst.xfer(8'hff, i == n - 1, rx, ak);
            else put(d[23-8*i -: 8]);
            if (rd) chk("read", 16'(rx), 16'(d[23-8*i -: 8]));
        end
        i_mst.stop_c();
    endtask
    // Bounded wait for the interrupt level, then compare
    task automatic int_is(logic e);
        for (int i = 0; i < 24 && int_oe !== e; i++) @(negedge clk_sys);
        chk("int", 16'(int_oe), 16'(e));
    endtask
    task automatic t_read;
        seq(CMD_IN0, {io_in[7:0], io_in[15:8], io_in[7:0]}, 3, 1'b1);
        int_is(1'b0);
    endtask
    task automatic t_int;
        io_in[3] = ~io_in[3];
        int_is(1'b1);
        io_in[3] = ~io_in[3];
        int_is(1'b0);
        io_in = io_in ^ 16'h1008;
        int_is(1'b1);
        seq(CMD_IN1, {io_in[15:8], 16'h0000}, 1, 1'b1);
        int_is(1'b1);
        seq(CMD_IN0, {io_in[7:0], 16'h0000}, 1, 1'b1);
        int_is(1'b0);
    endtask
    task automatic t_cfg;
        seq(CMD_CFG0, 24'h0ff000, 2, 1'b0);
        chk("oe", io_oe, 16'h0ff0);
        i_mst.extra = 15;
        seq(CMD_OUT0, 24'ha55a3c, 3, 1'b0);
        i_mst.extra = 0;
        chk("out", io_out, 16'h5a3c);
        io_in[5] = ~io_in[5];
        repeat (24) @(negedge clk_sys);
        int_is(1'b0);
        // Turning the output back into an input exposes the stale captured level
        seq(CMD_CFG0, 24'hff0000, 1, 1'b0);
        int_is(1'b1);
        seq(CMD_POL0, 24'hff0000, 1, 1'b0);
        seq(CMD_IN0, {~io_in[7:0], 16'h0000}, 1, 1'b1);
        int_is(1'b0);
    endtask
    // Foreign address must go unanswered
    task automatic t_miss;
        logic [7:0] rx;
        logic ak;
        i_mst.start_c();
        i_mst.xfer({ADDR_HI, ~sel, 1'b0}, 1'b1, rx, ak);
        chk("miss", 16'(ak), 16'h0001);
        i_mst.stop_c();
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        reset = 1'b0;
        repeat (4) @(negedge clk_sys);
        t_read();
        t_int();
        t_cfg();
        t_miss();
        stop_test();
    end
    // Hang guard well above the expected run length
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            failures++;
            stop_test();
        end
    end
endmodule
